// ---- src/eiq_map.vh ----
/*
 * constants of the external interrupt 0 aggregator: register addresses,
 * field positions, reset values, priority levels and vectors.
 * assumes the core's 16-bit external data address space.
 */
`ifndef EIQ_MAP_VH
`define EIQ_MAP_VH

`define EIQ_ADDR_FLAGS 16'h7F00
`define EIQ_ADDR_ENABLES 16'h7F01
`define EIQ_ADDR_CONFIG0 16'h7FF4
`define EIQ_RST_FLAGS 8'h00
`define EIQ_RST_ENABLES 8'h00
`define EIQ_RST_CONFIG0 8'h00
`define EIQ_CFG_KBD_SEL 4
`define EIQ_BIT_KBD_D 7
`define EIQ_BIT_KBD_C 6
`define EIQ_BIT_KBD_B 5
`define EIQ_BIT_KBD_A 4
`define EIQ_BIT_TWB2 3
`define EIQ_BIT_WAKE4 2
`define EIQ_BIT_WAKE2 1
`define EIQ_BIT_WAKE3 0
`define EIQ_PRIO_NONE 2'h0
`define EIQ_PRIO_LOW 2'h1
`define EIQ_PRIO_HIGH 2'h2
`define EIQ_PRIO_PFAIL 2'h3
`define EIQ_VEC_NONE 8'h00
`define EIQ_VEC_PFAIL 8'h33
`define EIQ_VEC_IRQ0 8'h03
`define EIQ_VEC_SERIAL0 8'h23
`define EIQ_IE_IRQ0 0
`define EIQ_IE_SERIAL0 4
`define EIQ_PRIO_SERIAL0 5

`endif

// ---- src/eiq_edge_wake.v ----
/*
 * wake event detector for one pin: trigger kind chosen by parameter.
 * assumes the pin level is already synchronous to clk.
 */
module eiq_edge_wake #(
    parameter KIND = 2,
    parameter FIXED_RISE = 1
) (
    input wire clk,
    input wire rst_n,
    input wire pin,
    input wire sel_rise,
    output wire event_pulse
);
    // kind: 0 fixed edge, 1 selectable edge, 2 either edge
    reg pin_last;
    reg primed;
    wire rise;
    wire fall;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_last <= 1'b0;
            primed <= 1'b0;
        end
        else
        begin
            pin_last <= pin;
            primed <= 1'b1;
        end
    end

    // first sampled level after reset is not an edge
    assign rise = primed & pin & ~pin_last;
    assign fall = primed & ~pin & pin_last;
    assign event_pulse = (KIND == 2) ? (rise | fall) :
                         (KIND == 1) ? (sel_rise ? rise : fall) :
                         (FIXED_RISE ? rise : fall);
endmodule

// ---- src/eiq_aggregator.v ----
/*
 * external interrupt 0 aggregator: latches eight peripheral and wake
 * events into a write-one-to-clear flag register, gates them by an
 * active-low mask and drives the core's active-low interrupt 0 line.
 * also holds the keyboard logic select, a wake line for sleep restart
 * and a small priority resolver for power-fail, irq0 and serial port 0.
 * assumes a synchronous single-cycle core data bus (addr, wdata, wr, rd)
 * and event inputs that are synchronous levels of the core clock.
 */
// Functional notes
// - OR of enabled flags drives irq0 low
// - writing one clears a flag bit
// - mask zero enables, one blocks source
// - masked sources still latch and read back
// - mask register read/write, resets to zero
// - bits 7,6 keyboard D,C when selected
// - bits 5,4 keyboard B,A or legacy ports
// - bit 3 sets on bus controller 2 irq
// - power-fail above high above low priority
// - serial 0: priority 5, IE.4, vector 23h
// - wake line gathers wakes, restarts sleep
// - wake triggers: fixed, selectable, either edge
// - wake events follow the physical pin
// - irq 0-4 run-time, irq 5 wake
// - bits 2,1,0 latch pin 4,2,3 edges
// - keyboard logic select defaults to zero
`include "eiq_map.vh"

module eiq_aggregator #(
    parameter WIDTH = 8
) (
    input wire clk,
    input wire rst_b,
    input wire [15:0] bus_addr,
    input wire [7:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    output reg [7:0] bus_rdata,
    input wire kbd_channel_d_irq,
    input wire kbd_channel_c_irq,
    input wire kbd_channel_b_irq,
    input wire kbd_channel_a_irq,
    input wire legacy_port2_irq,
    input wire legacy_port1_irq,
    input wire twb2_irq,
    input wire either_edge_wake_four,
    input wire either_edge_wake_two,
    input wire either_edge_wake_three,
    input wire [WIDTH-1:0] other_wake_events,
    input wire pfail_irq,
    input wire pfail_enable,
    input wire serial0_irq,
    input wire [7:0] core_ie,
    input wire [7:0] core_ip,
    output reg ext_irq_zero_n,
    output reg wake_irq_n,
    output reg kbd_port_logic_select,
    output reg [1:0] irq_level,
    output reg [7:0] irq_vector
);
    reg rst_sync1;
    reg rst_sync2;
    wire rst_n;
    reg [7:0] irq0_source_flags;
    reg [7:0] irq0_source_enables;
    reg [7:0] config0;
    reg [7:0] src_last;
    reg [7:0] next_flags;
    reg [7:0] next_rdata;
    reg [1:0] next_level;
    reg [7:0] next_vector;
    wire [7:0] src_now;
    wire [7:0] src_rise;
    wire wake4_ev;
    wire wake2_ev;
    wire wake3_ev;
    wire wr_flags;
    wire wr_enables;
    wire wr_config;
    wire [7:0] pending;
    wire irq0_req;
    wire ser_req;
    wire irq0_high;
    wire ser_high;

    function is_addr;
        input [15:0] a;
        input [15:0] target;
        begin
            is_addr = (a == target);
        end
    endfunction

    // reset release through two flops
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_sync1 <= 1'b0;
            rst_sync2 <= 1'b0;
        end
        else
        begin
            rst_sync1 <= 1'b1;
            rst_sync2 <= rst_sync1;
        end
    end
    assign rst_n = rst_sync2;

    assign wr_flags = bus_wr & is_addr(bus_addr, `EIQ_ADDR_FLAGS);
    assign wr_enables = bus_wr & is_addr(bus_addr, `EIQ_ADDR_ENABLES);
    assign wr_config = bus_wr & is_addr(bus_addr, `EIQ_ADDR_CONFIG0);

    // events taken from pin levels, any alternate function
    eiq_edge_wake #(
        .KIND(2),
        .FIXED_RISE(1)
    ) u_wake4 (
        .clk(clk),
        .rst_n(rst_n),
        .pin(either_edge_wake_four),
        .sel_rise(1'b0),
        .event_pulse(wake4_ev)
    );

    eiq_edge_wake #(
        .KIND(2),
        .FIXED_RISE(1)
    ) u_wake2 (
        .clk(clk),
        .rst_n(rst_n),
        .pin(either_edge_wake_two),
        .sel_rise(1'b0),
        .event_pulse(wake2_ev)
    );

    eiq_edge_wake #(
        .KIND(2),
        .FIXED_RISE(1)
    ) u_wake3 (
        .clk(clk),
        .rst_n(rst_n),
        .pin(either_edge_wake_three),
        .sel_rise(1'b0),
        .event_pulse(wake3_ev)
    );

    // channels D,C only while keyboard logic selected
    // bits 5,4 multiplexed by the select
    assign src_now[`EIQ_BIT_KBD_D] = kbd_port_logic_select & kbd_channel_d_irq;
    assign src_now[`EIQ_BIT_KBD_C] = kbd_port_logic_select & kbd_channel_c_irq;
    assign src_now[`EIQ_BIT_KBD_B] = kbd_port_logic_select ? kbd_channel_b_irq
                                                           : legacy_port2_irq;
    assign src_now[`EIQ_BIT_KBD_A] = kbd_port_logic_select ? kbd_channel_a_irq
                                                           : legacy_port1_irq;
    assign src_now[`EIQ_BIT_TWB2] = twb2_irq;
    assign src_now[2:0] = 3'h0;

    // level sources latch on assertion so a clear is not undone at once
    assign src_rise = src_now & ~src_last;

    // write-one clear, set wins and zero keeps
    // pin 4, 2, 3 edges into bits 2, 1, 0
    always @*
    begin
        next_flags = irq0_source_flags;
        if (wr_flags)
            next_flags = next_flags & ~bus_wdata;
        next_flags = next_flags | {src_rise[7:3], wake4_ev, wake2_ev, wake3_ev};
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq0_source_flags <= `EIQ_RST_FLAGS;
            irq0_source_enables <= `EIQ_RST_ENABLES;
            config0 <= `EIQ_RST_CONFIG0;
            src_last <= 8'h00;
        end
        else
        begin
            irq0_source_flags <= next_flags;
            src_last <= src_now;
            if (wr_enables)
                irq0_source_enables <= bus_wdata;
            // select resets to zero (legacy ports)
            if (wr_config)
                config0 <= bus_wdata;
        end
    end

    // zero in the mask enables the source
    assign pending = irq0_source_flags & ~irq0_source_enables;
    assign irq0_req = |pending;

    always @*
    begin
        next_rdata = 8'h00;
        if (bus_rd)
        begin
            if (is_addr(bus_addr, `EIQ_ADDR_FLAGS))
                next_rdata = irq0_source_flags;
            else if (is_addr(bus_addr, `EIQ_ADDR_ENABLES))
                next_rdata = irq0_source_enables;
            else if (is_addr(bus_addr, `EIQ_ADDR_CONFIG0))
                next_rdata = config0;
        end
    end

    // power-fail first, then high, then low
    // serial port 0 gated by IE.4, priority IP.4, vector 23h
    // irq0 is run-time; priority 1 beats serial's 5 in a level
    assign ser_req = serial0_irq & core_ie[`EIQ_IE_SERIAL0];
    assign irq0_high = core_ip[`EIQ_IE_IRQ0];
    assign ser_high = core_ip[`EIQ_PRIO_SERIAL0 - 1];

    always @*
    begin
        next_level = `EIQ_PRIO_NONE;
        next_vector = `EIQ_VEC_NONE;
        if (pfail_irq & pfail_enable)
        begin
            next_level = `EIQ_PRIO_PFAIL;
            next_vector = `EIQ_VEC_PFAIL;
        end
        else if (irq0_req & core_ie[`EIQ_IE_IRQ0] & irq0_high)
        begin
            next_level = `EIQ_PRIO_HIGH;
            next_vector = `EIQ_VEC_IRQ0;
        end
        else if (ser_req & ser_high)
        begin
            next_level = `EIQ_PRIO_HIGH;
            next_vector = `EIQ_VEC_SERIAL0;
        end
        else if (irq0_req & core_ie[`EIQ_IE_IRQ0])
        begin
            next_level = `EIQ_PRIO_LOW;
            next_vector = `EIQ_VEC_IRQ0;
        end
        else if (ser_req)
        begin
            next_level = `EIQ_PRIO_LOW;
            next_vector = `EIQ_VEC_SERIAL0;
        end
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_irq_zero_n <= 1'b1;
            wake_irq_n <= 1'b1;
            kbd_port_logic_select <= 1'b0;
            bus_rdata <= 8'h00;
            irq_level <= `EIQ_PRIO_NONE;
            irq_vector <= `EIQ_VEC_NONE;
        end
        else
        begin
            ext_irq_zero_n <= ~(|(next_flags & ~(wr_enables ? bus_wdata
                                                            : irq0_source_enables)));
            // any wake source restarts from sleep
            wake_irq_n <= ~(wake4_ev | wake2_ev | wake3_ev | (|other_wake_events));
            kbd_port_logic_select <= wr_config ? bus_wdata[`EIQ_CFG_KBD_SEL]
                                               : config0[`EIQ_CFG_KBD_SEL];
            bus_rdata <= next_rdata;
            irq_level <= next_level;
            irq_vector <= next_vector;
        end
    end
endmodule

// ---- bench/eiq_chk_sva.sv ----
/* port assertions for the irq0 aggregator.
   assumes one clock and rst_b, bound to the top module. */
module eiq_chk (
    input logic clk,
    input logic rst_b,
    input logic [15:0] bus_addr,
    input logic [7:0] bus_wdata,
    input logic bus_wr,
    input logic bus_rd,
    input logic [7:0] bus_rdata,
    input logic either_edge_wake_four,
    input logic pfail_irq,
    input logic pfail_enable,
    input logic ext_irq_zero_n,
    input logic wake_irq_n,
    input logic kbd_port_logic_select,
    input logic [1:0] irq_level,
    input logic [7:0] irq_vector
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    wire mapped = bus_addr == 16'h7F00 || bus_addr == 16'h7F01 || bus_addr == 16'h7FF4;
    sequence s_mask_wr;
        bus_wr && bus_addr == 16'h7F01;
    endsequence
    sequence s_mask_rd;
        bus_rd && bus_addr == 16'h7F01;
    endsequence
    sequence s_mask_all;
        bus_wr && bus_addr == 16'h7F01 && bus_wdata == 8'hFF;
    endsequence
    a_rd_unmapped: assert property (bus_rd && !mapped |=> bus_rdata == 8'h00)
        else $error("unmapped read data");
    a_rd_idle: assert property (!bus_rd |=> bus_rdata == 8'h00)
        else $error("read data without read");
    a_mask_back: assert property (s_mask_wr ##2 s_mask_rd |=> bus_rdata == $past(bus_wdata, 3))
        else $error("mask readback");
    a_mask_block: assert property (s_mask_all |=> ext_irq_zero_n [*3])
        else $error("irq0 with all masked");
    a_irq_release: assert property ($rose(ext_irq_zero_n) |-> $past(bus_wr))
        else $error("irq0 dropped without write");
    a_sel_follow: assert property (bus_wr && bus_addr == 16'h7FF4
        |=> kbd_port_logic_select == $past(bus_wdata[4]))
        else $error("select bit");
    a_wake_edge: assert property (either_edge_wake_four != $past(either_edge_wake_four)
        |-> ##[1:3] !wake_irq_n)
        else $error("no wake pulse");
    a_pfail_first: assert property (pfail_irq && pfail_enable
        |=> irq_level == 2'h3 && irq_vector == 8'h33)
        else $error("power fail priority");
endmodule
bind eiq_aggregator eiq_chk chk (.clk, .rst_b, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .bus_rdata, .either_edge_wake_four, .pfail_irq, .pfail_enable, .ext_irq_zero_n,
    .wake_irq_n, .kbd_port_logic_select, .irq_level, .irq_vector);

// ---- bench/eiq_core_model.sv ----
/* core side: byte reads and writes on the aggregator data bus.
   assumes callers enter tasks after a clock edge. */
module eiq_core_model (
    input logic clk,
    output logic [15:0] bus_addr,
    output logic [7:0] bus_wdata,
    output logic bus_wr,
    output logic bus_rd,
    input logic [7:0] bus_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        bus_addr = 16'h0000;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
        // released data no longer shows the byte
        bus_wdata <= ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] q);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        q = bus_rdata;
    endtask
endmodule

// ---- bench/tb_top.sv ----
/* bench for the irq0 aggregator: event rows, then mask, clear and priority.
   assumes the core model and the bound checker. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, pfail_irq, pfail_enable, serial0_irq, bus_wr, bus_rd;
    logic ext_irq_zero_n, wake_irq_n, kbd_port_logic_select;
    logic [9:0] ev;
    logic [15:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata, core_ie, core_ip, other_wake, irq_vector, q;
    logic [1:0] irq_level;
    int mismatches, total_checks, cycles, i;
    // select bit, event index, expected flags
    logic [12:0] rows [12] = '{{1'b0, 4'h9, 8'h00}, {1'b0, 4'h5, 8'h20}, {1'b0, 4'h4, 8'h10},
        {1'b0, 4'h3, 8'h08}, {1'b0, 4'h2, 8'h04}, {1'b0, 4'h1, 8'h02}, {1'b0, 4'h0, 8'h01},
        {1'b1, 4'h9, 8'h80}, {1'b1, 4'h8, 8'h40}, {1'b1, 4'h7, 8'h20}, {1'b1, 4'h6, 8'h10},
        {1'b1, 4'h5, 8'h00}};
    eiq_aggregator dut (.clk, .rst_b, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
        .kbd_channel_d_irq(ev[9]), .kbd_channel_c_irq(ev[8]), .kbd_channel_b_irq(ev[7]),
        .kbd_channel_a_irq(ev[6]), .legacy_port2_irq(ev[5]), .legacy_port1_irq(ev[4]),
        .twb2_irq(ev[3]), .either_edge_wake_four(ev[2]), .either_edge_wake_two(ev[1]),
        .either_edge_wake_three(ev[0]), .other_wake_events(other_wake), .pfail_irq, .pfail_enable,
        .serial0_irq, .core_ie, .core_ip, .ext_irq_zero_n, .wake_irq_n,
        .kbd_port_logic_select, .irq_level, .irq_vector);
    eiq_core_model core (.clk, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata);
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test();
        if (mismatches == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            mismatches++;
            end_of_test();
        end
    end
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        {rst_b, pfail_irq, pfail_enable, serial0_irq, ev, core_ie, core_ip, other_wake} = '0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        core.rd(16'h7F00, q);
        chk("flags", q, 8'h00);
        core.rd(16'h7F01, q);
        chk("enables", q, 8'h00);
        core.rd(16'h7FF4, q);
        chk("select", {q[4], kbd_port_logic_select}, 2'h0);
        for (i = 0; i < 12; i++)
        begin
            core.wr(16'h7FF4, {3'h0, rows[i][12], 4'h0});
            ev[rows[i][11:8]] <= 1'b1;
            repeat (3) @(posedge clk);
            core.rd(16'h7F00, q);
            chk("flags", q, rows[i][7:0]);
            chk("irq0", ext_irq_zero_n, rows[i][7:0] == 8'h00);
            @(posedge clk);
            ev[rows[i][11:8]] <= 1'b0;
            repeat (3) @(posedge clk);
            core.wr(16'h7F00, 8'hFF);
            #1;
            chk("irq0 clear", ext_irq_zero_n, 1'b1);
        end
        core.wr(16'h7F01, 8'hFF);
        ev[3] <= 1'b1;
        repeat (3) @(posedge clk);
        core.rd(16'h7F00, q);
        chk("masked flags", q, 8'h08);
        chk("masked irq0", ext_irq_zero_n, 1'b1);
        core.wr(16'h7F01, 8'h00);
        #1;
        chk("unmasked irq0", ext_irq_zero_n, 1'b0);
        core.wr(16'h7F00, 8'h00);
        core.rd(16'h7F00, q);
        chk("zero keeps", q, 8'h08);
        core.wr(16'h7F00, 8'h08);
        repeat (3) @(posedge clk);
        core.rd(16'h7F00, q);
        chk("held level", q, 8'h00);
        @(posedge clk);
        ev[3] <= 1'b0;
        repeat (2) @(posedge clk);
        // new assertion and write-one clear meet at one edge
        fork
            core.wr(16'h7F00, 8'h08);
            begin
                @(posedge clk);
                ev[3] <= 1'b1;
            end
        join
        core.rd(16'h7F00, q);
        chk("set over clear", q, 8'h08);
        core.wr(16'h7F01, 8'hA5);
        core.rd(16'h7F01, q);
        chk("enables", q, 8'hA5);
        core.rd(16'h1234, q);
        chk("unmapped", q, 8'h00);
        @(posedge clk);
        serial0_irq <= 1'b1;
        core_ie <= 8'h10;
        repeat (2) @(posedge clk);
        #1;
        chk("serial", {irq_level, irq_vector}, {2'h1, 8'h23});
        @(posedge clk);
        {pfail_irq, pfail_enable} <= 2'h3;
        repeat (2) @(posedge clk);
        #1;
        chk("pfail", {irq_level, irq_vector}, {2'h3, 8'h33});
        @(posedge clk);
        {pfail_irq, pfail_enable} <= 2'h0;
        core_ie <= 8'h11;
        core_ip <= 8'h10;
        repeat (2) @(posedge clk);
        #1;
        chk("serial high", {irq_level, irq_vector}, {2'h2, 8'h23});
        @(posedge clk);
        core_ip <= 8'h11;
        repeat (2) @(posedge clk);
        #1;
        chk("irq0 high", {irq_level, irq_vector}, {2'h2, 8'h03});
        @(posedge clk);
        core_ip <= 8'h00;
        other_wake <= 8'h04;
        repeat (2) @(posedge clk);
        #1;
        chk("irq0 low", {irq_level, irq_vector}, {2'h1, 8'h03});
        chk("wake line", wake_irq_n, 1'b0);
        @(posedge clk);
        other_wake <= 8'h00;
        repeat (2) @(posedge clk);
        #1;
        chk("wake idle", wake_irq_n, 1'b1);
        end_of_test();
    end
endmodule
